// ==== ccg_pkg.sv ====
// package of constants for the cpu to cipher port glue
package ccg_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] CIPHER_PORT_ADDR_RST = 8'h00;
	localparam int unsigned MCLK_HZ = 200000000;
	localparam int unsigned CPU_CLK_MAX_HZ = 2200000;
	// least number of mclk cycles per half period of the cpu clock (rounded up)
	localparam int unsigned HALF_PERIOD_MIN_CYC =
		(MCLK_HZ + 2 * CPU_CLK_MAX_HZ - 1) / (2 * CPU_CLK_MAX_HZ);
	localparam logic [7:0] HALF_PERIOD_RST = 8'((HALF_PERIOD_MIN_CYC > 255) ? 255 :
		HALF_PERIOD_MIN_CYC);
	typedef enum logic [1:0] {
		CCG_IDLE,
		CCG_SELECTED,
		CCG_BLOCKED
	} ccg_cycle_e;
endpackage

// ==== ccg_clk_div.sv ====
// divider that paces the shared processor clock
`timescale 1ns/1ps
`default_nettype none
module ccg_clk_div (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] half_period,
	output logic tick
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic tick_d;

	always_comb begin
		tick_d = 1'b0;
		cnt_d = cnt_q + 8'h01;
		if (cnt_q + 8'h01 >= half_period) begin
			cnt_d = 8'h00;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cnt_q <= 8'h00;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= tick_d;
		end
	end
endmodule
`default_nettype wire

// ==== ccg_top.sv ====
// glue between a multiplexed-bus processor and the cipher processor master port
// How it works
// - processor address/data bus passes to the cipher master port through one mclk register, no address latch.
// - master data strobe active while read or write strobe is active, only in a cycle selected at address latch.
// - master read/write select follows status line one directly.
// - master address strobe is the inverse of address latch pulse.
// - chip select low only on address match and io access, registered every mclk cycle.
// - decode uses the upper address byte, stable for the whole cycle.
// - cipher clock is the inverted processor clock, common clock at most 2.2 MHz.
`timescale 1ns/1ps
`default_nettype none
module ccg_top (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] port_addr,
	input wire logic [7:0] cpu_ad_in,
	input wire logic [7:0] cpu_ad_out,
	input wire logic cpu_ad_oe,
	input wire logic [7:0] cpu_addr_hi,
	input wire logic cpu_rd_n,
	input wire logic cpu_wr_n,
	input wire logic status_line_one,
	input wire logic cpu_ale,
	input wire logic cpu_io_mem_n,
	input wire logic [7:0] cipher_ad_out,
	input wire logic cipher_ad_oe,
	output logic [7:0] cipher_ad_in,
	output logic [7:0] cpu_ad_drive,
	output logic cpu_ad_drive_oe,
	output logic cpu_clk,
	output logic cipher_clk,
	output logic master_data_strobe_n,
	output logic master_address_strobe_n,
	output logic master_read_write_select,
	output logic master_chip_select_n
);
	// ***********************
	// clock generation
	// ***********************
	logic tick;
	logic cpu_clk_d;

	ccg_clk_div u_div (
		.mclk(mclk),
		.resetn(resetn),
		.half_period(ccg_pkg::HALF_PERIOD_RST),
		.tick(tick)
	);

	always_comb begin
		cpu_clk_d = cpu_clk;
		if (tick) begin
			cpu_clk_d = ~cpu_clk;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cpu_clk <= 1'b0;
			cipher_clk <= 1'b1;
		end else begin
			cpu_clk <= cpu_clk_d;
			cipher_clk <= ~cpu_clk_d;
		end
	end

	// ***********************
	// bus pass-through
	// ***********************
	logic [7:0] cipher_ad_in_d;
	logic [7:0] cpu_ad_drive_d;
	logic cpu_ad_drive_oe_d;

	always_comb begin
		cipher_ad_in_d = cpu_ad_oe ? cpu_ad_out : cpu_ad_in;
		cpu_ad_drive_d = cipher_ad_out;
		cpu_ad_drive_oe_d = cipher_ad_oe;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cipher_ad_in <= 8'h00;
			cpu_ad_drive <= 8'h00;
			cpu_ad_drive_oe <= 1'b0;
		end else begin
			cipher_ad_in <= cipher_ad_in_d;
			cpu_ad_drive <= cpu_ad_drive_d;
			cpu_ad_drive_oe <= cpu_ad_drive_oe_d;
		end
	end

	// ***********************
	// strobes and chip select
	// ***********************
	ccg_pkg::ccg_cycle_e cyc_q;
	ccg_pkg::ccg_cycle_e cyc_d;
	logic sel_hit;
	logic mds_n_d;
	logic mas_n_d;
	logic mcs_n_d;
	logic rw_d;

	always_comb begin
		sel_hit = (cpu_addr_hi == port_addr) && cpu_io_mem_n;
		mas_n_d = ~cpu_ale;
		mcs_n_d = ~sel_hit;
		rw_d = status_line_one;
		cyc_d = cyc_q;
		if (cpu_ale) begin
			cyc_d = sel_hit ? ccg_pkg::CCG_SELECTED : ccg_pkg::CCG_BLOCKED;
		end
		mds_n_d = 1'b1;
		unique case (cyc_q)
			ccg_pkg::CCG_IDLE: mds_n_d = 1'b1;
			ccg_pkg::CCG_SELECTED: mds_n_d = cpu_rd_n & cpu_wr_n;
			ccg_pkg::CCG_BLOCKED: mds_n_d = 1'b1;
			default: mds_n_d = 1'b1;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cyc_q <= ccg_pkg::CCG_IDLE;
			master_data_strobe_n <= 1'b1;
			master_address_strobe_n <= 1'b1;
			master_read_write_select <= 1'b0;
			master_chip_select_n <= 1'b1;
		end else begin
			cyc_q <= cyc_d;
			master_data_strobe_n <= mds_n_d;
			master_address_strobe_n <= mas_n_d;
			master_read_write_select <= rw_d;
			master_chip_select_n <= mcs_n_d;
		end
	end
endmodule
`default_nettype wire

// ==== ccg_chk.sv ====
// glue port checker
`timescale 1ns/1ps
`default_nettype none
module ccg_chk (
	input wire logic mclk, resetn, cpu_rd_n, cpu_wr_n, status_line_one, cpu_ale, cpu_io_mem_n,
	input wire logic cpu_clk, cipher_clk, master_data_strobe_n, master_address_strobe_n,
	input wire logic master_read_write_select, master_chip_select_n,
	input wire logic [7:0] port_addr, cpu_addr_hi
);
	logic run_q;
	always_ff @(posedge mclk) run_q <= resetn;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn || !run_q);
	a_ds_cause: assert property (!master_data_strobe_n |->
		!$past(cpu_rd_n) || !$past(cpu_wr_n)) else $error("ds");
	a_rw_follow: assert property (master_read_write_select == $past(status_line_one))
		else $error("rw");
	a_as_invert: assert property (master_address_strobe_n != $past(cpu_ale)) else $error("as");
	a_cs_io: assert property (!$past(cpu_io_mem_n) |-> master_chip_select_n) else $error("io");
	a_cs_match: assert property (master_chip_select_n !=
		($past(cpu_addr_hi) == port_addr && $past(cpu_io_mem_n))) else $error("cs");
	a_clk_inv: assert property ($stable(cpu_clk) |-> cipher_clk != cpu_clk) else $error("ck");
	a_clk_hold: assert property ($changed(cpu_clk) |=> $stable(cpu_clk) [*8]) else $error("hd");
	a_ds_block: assert property (!master_address_strobe_n && master_chip_select_n |=>
		master_data_strobe_n [*2]) else $error("bl");
	cover property (!master_data_strobe_n);
	cover property (!master_address_strobe_n);
	cover property ($rose(cpu_clk));
endmodule
`default_nettype wire

// ==== ccg_cpu.sv ====
// processor bus model
`timescale 1ns/1ps
`default_nettype none
module ccg_cpu (
	input wire logic mclk,
	output logic cpu_ale, cpu_rd_n, cpu_wr_n, status_line_one, cpu_io_mem_n, cpu_ad_oe,
	output logic [7:0] cpu_addr_hi, cpu_ad_out
);
	initial {cpu_ale, cpu_rd_n, cpu_wr_n, status_line_one, cpu_io_mem_n, cpu_ad_oe,
		cpu_addr_hi, cpu_ad_out} = 22'h180000;
	// one bus cycle; a write drives the inverse of the address as data
	task cyc(input logic [7:0] a, input logic io, input logic w, input logic al);
		@(posedge mclk);
		{cpu_rd_n, cpu_wr_n, cpu_ale, status_line_one, cpu_io_mem_n} <= {2'h3, al, !w, io};
		{cpu_addr_hi, cpu_ad_out, cpu_ad_oe} <= {a, a, 1'b1};
		@(posedge mclk) cpu_ale <= 1'b0;
		@(posedge mclk) {cpu_rd_n, cpu_wr_n, cpu_ad_out, cpu_ad_oe} <= {w, !w, ~a, w};
		@(posedge mclk) #1;
	endtask
endmodule
`default_nettype wire

// ==== tb_ccg_top.sv ====
// glue testbench
`timescale 1ns/1ps
`default_nettype none
module tb_ccg_top;
	logic mclk = 1'b0, resetn = 1'b0, c, cpu_ale, cpu_rd_n, cpu_wr_n, status_line_one;
	logic cpu_io_mem_n, cpu_ad_oe, cpu_ad_drive_oe, cpu_clk, cipher_clk, cipher_ad_oe;
	logic master_data_strobe_n, master_address_strobe_n, master_read_write_select;
	logic master_chip_select_n;
	logic [7:0] port_addr = 8'ha5, cipher_ad_out = 8'h3c;
	logic [7:0] cpu_addr_hi, cpu_ad_out, cpu_ad_in, cipher_ad_in, cpu_ad_drive;
	// rows: upper address byte, io, write, expected hit
	logic [10:0] rows [5] = '{11'h52d, 11'h52f, 11'h52a, 11'h2d4, 11'h52d};
	int errors = 0, checks = 0, n;
	always #2.5 mclk = ~mclk;
	assign cpu_ad_in = cpu_ad_oe ? cpu_ad_out : cpu_ad_drive;
	assign cipher_ad_oe = master_read_write_select && !master_data_strobe_n;
	ccg_cpu ccg_cpu_inst (.*);
	ccg_top ccg_top_inst (.*);
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task final_report;
		if (errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		#1 chk("rst", 8'({master_data_strobe_n, master_chip_select_n, cpu_clk}), 8'h06);
		@(posedge mclk) resetn <= 1'b1;
		foreach (rows[k]) begin
			ccg_cpu_inst.cyc(rows[k][10:3], rows[k][2], rows[k][1], 1'b1);
			chk("row", 8'({master_data_strobe_n, master_read_write_select,
				master_chip_select_n}), 8'({!rows[k][0], !rows[k][1], !rows[k][0]}));
		end
		@(posedge mclk) resetn <= 1'b0;
		@(posedge mclk) resetn <= 1'b1;
		ccg_cpu_inst.cyc(port_addr, 1'b1, 1'b1, 1'b0);
		chk("gate", 8'(master_data_strobe_n), 8'h01);
		chk("ad_in", cipher_ad_in, ~port_addr);
		chk("ad_drv", cpu_ad_drive, cipher_ad_out);
		for (int i = 0; i < 2; i++) begin
			c = cpu_clk;
			for (n = 0; n < 99 && cpu_clk === c; n++) @(posedge mclk) #1;
		end
		chk("clk", 8'(n), 8'(ccg_pkg::HALF_PERIOD_MIN_CYC));
		chk("cclk", 8'(cipher_clk), 8'(!cpu_clk));
		final_report;
	end
endmodule
bind ccg_top ccg_chk ccg_chk_inst (.*);
`default_nettype wire
